// ==== inc/acso_pkg.sv ====
package acso_pkg;

  // Frame shape
  localparam int FRAME_BITS = 24;                  // Bits per read
  localparam int CNT_W      = 5;                   // Falling-edge counter width
  localparam int RES_W      = 17;                  // Result field width
  localparam int VAL_W      = 20;                  // Raw signed value from the modulator
  localparam int GAIN_W     = 3;                   // Gain select width
  localparam int REJ_W      = 2;                   // Rejection mode width

  // Frame field positions
  localparam int EOC_POS    = 23;                  // Conversion-done flag, active low
  localparam int FILL_POS   = 22;                  // Filler bit
  localparam int SIGN_POS   = 21;                  // Sign flag
  localparam int MSB_POS    = 20;                  // Result MSB
  localparam int GAIN_POS   = 1;                   // Gain bits 3..1
  localparam int TEMP_POS   = 0;                   // Temperature select bit
  localparam logic [CNT_W-1:0] LAST_FALL = 5'h17;  // Count value at the 24th fall

  // Clamp codes: +FS + 1 LSB and -FS - 1 LSB
  localparam logic signed [VAL_W-1:0] POS_CLAMP = 20'sh10000;
  localparam logic signed [VAL_W-1:0] NEG_CLAMP = 20'shEFFFF;

  // Rejection modes
  localparam logic [REJ_W-1:0] REJ_BOTH = 2'h0;    // Simultaneous 50/60 Hz, reset value
  localparam logic [REJ_W-1:0] REJ_50   = 2'h1;    // 50 Hz only
  localparam logic [REJ_W-1:0] REJ_60   = 2'h2;    // 60 Hz only

  // Timing
  localparam int CLK_MHZ          = 100;           // System clock rate
  localparam int EXT_MIN_FREQ_KHZ = 10;            // Slowest detectable external clock
  localparam int EXT_TIMEOUT_CYC  = (CLK_MHZ * 1000) / EXT_MIN_FREQ_KHZ;
  localparam int NOTCH_DIV        = 5120;          // Conversion clocks per notch period
  localparam int INT_OSC_DIV      = 32;            // System clocks per internal osc tick

  // Configuration carried to the analog core
  typedef struct packed {
    logic [GAIN_W-1:0] gain_select;                // Gain code
    logic              temp_input_select;          // Temperature sensor input
    logic              double_speed_select;        // 2x speed, no autocal
    logic [REJ_W-1:0]  reject_mode;                // Line rejection mode
  } acso_cfg_s;

  localparam acso_cfg_s CFG_RESET = '{gain_select: 3'h0, temp_input_select: 1'b0,
                                      double_speed_select: 1'b0, reject_mode: REJ_BOTH};

  // Result handed over by the modulator at conversion end
  typedef struct packed {
    logic                    valid;                // One-cycle completion strobe
    logic signed [VAL_W-1:0] value;                // Unclamped signed code
  } acso_result_s;

  typedef enum logic [1:0] {ST_CONVERT, ST_SLEEP, ST_OUTPUT} acso_state_e;

endpackage : acso_pkg

// ==== rtl/acso_top.sv ====
`timescale 1ns/100ps
module acso_top #(
  parameter int EXT_TIMEOUT = acso_pkg::EXT_TIMEOUT_CYC,  // Cycles without edge: clock absent
  parameter int OSC_DIV     = acso_pkg::INT_OSC_DIV,      // Internal oscillator divider
  parameter int NOTCH_CNT   = acso_pkg::NOTCH_DIV         // Conversion clocks per notch tick
) (
  input  wire logic                   clk,             // 100 MHz system clock
  input  wire logic                   reset,           // Synchronous, active high
  input  wire logic                   cs_n,            // Host chip select, active low
  input  wire logic                   sck,             // Host serial clock
  output logic                        serial_out,      // Serial data to host
  output logic                        serial_out_oe,   // Drive enable for serial_out
  input  wire logic                   cfg_load,        // Load new configuration
  input  wire acso_pkg::acso_cfg_s    cfg_in,          // Configuration word
  input  wire acso_pkg::acso_result_s result_in,       // Modulator result
  output logic                        conv_start,      // Start-of-conversion pulse
  output logic                        conv_busy,       // Conversion in progress
  output acso_pkg::acso_cfg_s         active_cfg,      // Config of running conversion
  input  wire logic                   conv_clock_pin,  // Frequency select pin
  output logic                        ext_clock_mode,  // External conversion clock in use
  output logic                        int_osc_enable,  // Internal oscillator enable
  output logic                        notch_tick       // One pulse per notch period
);
  import acso_pkg::*;

  localparam int TO_W = $clog2(EXT_TIMEOUT + 1);   // Idle counter width
  localparam int OD_W = $clog2(OSC_DIV + 1);       // Oscillator divider width
  localparam int NT_W = $clog2(NOTCH_CNT + 1);     // Notch counter width

  // Configuration state
  acso_cfg_s cfg_reg, cfg_next;                    // Programmed configuration
  acso_cfg_s eff_cfg;                              // Configuration as applied

  // Serial and conversion state
  acso_state_e             state_reg, state_next;  // Conversion cycle phase
  logic [FRAME_BITS-1:0]   shift_reg, shift_next;  // Output frame
  logic [CNT_W-1:0]        cnt_reg, cnt_next;      // Falling edges seen
  logic                    so_reg, so_next;        // Serial out level
  logic                    oe_reg, oe_next;        // Serial out enable
  logic                    sck_d_reg, sck_d_next;  // Last serial clock sample
  logic                    start_reg, start_next;  // Start pulse
  logic                    zsign_reg, zsign_next;  // Zero-code sign alternation
  logic                    busy_reg, busy_next;    // Conversion in progress
  acso_cfg_s               used_reg, used_next;    // Config tied to this conversion
  logic                    sck_fall;               // Falling serial clock edge
  logic signed [VAL_W-1:0] clamped;                // Result after clamping
  logic                    sign_bit;               // Frame sign flag
  logic [FRAME_BITS-1:0]   frame;                  // Assembled frame

  // Clock source state
  logic            pin_d_reg, pin_d_next;          // Last pin sample
  logic [TO_W-1:0] idle_reg, idle_next;            // Cycles since last pin rise
  logic            det_reg, det_next;              // External clock detected
  logic            ext_reg, ext_next;              // Source in use
  logic            osc_en_reg, osc_en_next;        // Oscillator enable output
  logic [OD_W-1:0] osc_reg, osc_next;              // Internal oscillator divider
  logic [NT_W-1:0] notch_reg, notch_next;          // Notch period counter
  logic            ntick_reg, ntick_next;          // Notch pulse
  logic            pin_rise;                       // Rising edge on pin
  logic            osc_tick;                       // Internal oscillator tick
  logic            conv_edge;                      // Conversion clock event

  // Configuration next value and applied form
  always_comb begin
    cfg_next = cfg_reg;
    // Reserved rejection code is stored as given; nothing here refuses it
    if (cfg_load) begin
      cfg_next = cfg_in;
    end
    eff_cfg = cfg_reg;
    if (cfg_reg.temp_input_select) begin
      eff_cfg.gain_select         = '0;
      eff_cfg.double_speed_select = 1'b0;
    end
  end

  // Configuration register; reset gives combined 50/60 Hz rejection
  always_ff @(posedge clk) begin
    if (reset) begin
      cfg_reg <= CFG_RESET;
    end else begin
      cfg_reg <= cfg_next;
    end
  end

  // Result clamp and frame assembly
  always_comb begin
    // Anything past full scale collapses onto one code beyond it
    if (result_in.value > POS_CLAMP) begin
      clamped = POS_CLAMP;
    end else if (result_in.value < NEG_CLAMP) begin
      clamped = NEG_CLAMP;
    end else begin
      clamped = result_in.value;
    end
    // Offset-binary sign: high for positive codes, and for zero unless double speed alternates it
    sign_bit = ~clamped[VAL_W-1];
    if (clamped == '0 && used_reg.double_speed_select) begin
      sign_bit = zsign_reg;
    end
    // Status leads and config trails, so one shift register serves the read
    frame = '0;
    frame[EOC_POS]  = 1'b0;
    frame[FILL_POS] = 1'b0;
    frame[SIGN_POS] = sign_bit;
    frame[MSB_POS -: RES_W] = clamped[RES_W-1:0];
    frame[GAIN_POS +: GAIN_W] = used_reg.gain_select;
    frame[TEMP_POS] = used_reg.temp_input_select;
  end

  // Conversion cycle and serial shifter next state
  always_comb begin
    // Serial clock is sampled as a level: a fall is high then low
    sck_fall   = sck_d_reg & ~sck;
    state_next = state_reg;
    shift_next = shift_reg;
    cnt_next   = cnt_reg;
    start_next = 1'b0;
    zsign_next = zsign_reg;
    used_next  = used_reg;
    sck_d_next = sck;
    case (state_reg)
      ST_CONVERT: begin
        // Clocks here are ignored; the frame is only built once the result lands
        if (result_in.valid) begin
          shift_next = frame;
          zsign_next = ~zsign_reg;
          state_next = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        // Select while asleep opens the read with the done flag already low
        if (!cs_n) begin
          cnt_next   = '0;
          state_next = ST_OUTPUT;
        end
      end
      ST_OUTPUT: begin
        if (cs_n) begin
          // Early release throws the rest of the frame away
          start_next = 1'b1;
          used_next  = eff_cfg;
          state_next = ST_CONVERT;
        end else if (sck_fall) begin
          // Last fall: line goes high and doubles as the next done flag
          if (cnt_reg == LAST_FALL) begin
            start_next = 1'b1;
            used_next  = eff_cfg;
            state_next = ST_CONVERT;
          end else begin
            shift_next = {shift_reg[FRAME_BITS-2:0], 1'b1};
            cnt_next   = cnt_reg + 5'h01;
          end
        end
      end
      default: begin
        // Stray encoding: recover into a fresh conversion
        state_next = ST_CONVERT;
      end
    endcase
    // Converting reads high, also covering clocks past the 24th
    if (state_next == ST_CONVERT) begin
      so_next = 1'b1;
    end else begin
      so_next = shift_next[FRAME_BITS-1];
    end
    oe_next = ~cs_n;
    // Busy kept in its own flop so the port is never a decode
    busy_next = (state_next == ST_CONVERT);
  end

  // Conversion cycle and serial shifter registers
  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg <= ST_CONVERT;
      shift_reg <= '0;
      cnt_reg   <= '0;
      so_reg    <= 1'b1;
      oe_reg    <= 1'b0;
      sck_d_reg <= 1'b0;
      start_reg <= 1'b1;                           // Conversion begins out of reset
      zsign_reg <= 1'b0;
      busy_reg  <= 1'b1;
      used_reg  <= CFG_RESET;
    end else begin
      state_reg <= state_next;
      shift_reg <= shift_next;
      cnt_reg   <= cnt_next;
      so_reg    <= so_next;
      oe_reg    <= oe_next;
      sck_d_reg <= sck_d_next;
      start_reg <= start_next;
      zsign_reg <= zsign_next;
      busy_reg  <= busy_next;
      used_reg  <= used_next;
    end
  end

  // Clock source detection and notch timing next state
  always_comb begin
    // Timeout spans one period of the slowest external clock still detected
    pin_d_next = conv_clock_pin;
    pin_rise   = conv_clock_pin & ~pin_d_reg;
    idle_next  = idle_reg;
    det_next   = det_reg;
    if (pin_rise) begin
      idle_next = '0;
      det_next  = 1'b1;
    end else if (idle_reg == TO_W'(EXT_TIMEOUT - 1)) begin
      det_next  = 1'b0;
    end else begin
      idle_next = idle_reg + 1'b1;
    end
    // Hold the source while converting so a swap cannot corrupt a result
    if (state_reg != ST_CONVERT) begin
      ext_next = det_reg;
    end else begin
      ext_next = ext_reg;
    end
    osc_en_next = ~ext_next;
    // Internal oscillator runs only when it is the chosen source
    osc_tick = 1'b0;
    osc_next = osc_reg;
    if (!ext_reg) begin
      if (osc_reg == OD_W'(OSC_DIV - 1)) begin
        osc_next = '0;
        osc_tick = 1'b1;
      end else begin
        osc_next = osc_reg + 1'b1;
      end
    end else begin
      osc_next = '0;
    end
    // Notch timing counts whichever conversion clock is in charge
    conv_edge  = ext_reg ? pin_rise : osc_tick;
    notch_next = notch_reg;
    ntick_next = 1'b0;
    if (conv_edge) begin
      if (notch_reg == NT_W'(NOTCH_CNT - 1)) begin
        notch_next = '0;
        ntick_next = 1'b1;
      end else begin
        notch_next = notch_reg + 1'b1;
      end
    end
  end

  // Clock source registers; internal oscillator assumed at reset
  always_ff @(posedge clk) begin
    if (reset) begin
      // Last sample preset high: no false rise whatever level the pin idles at
      pin_d_reg  <= 1'b1;
      idle_reg   <= '0;
      det_reg    <= 1'b0;
      ext_reg    <= 1'b0;
      osc_en_reg <= 1'b1;
      osc_reg    <= '0;
      notch_reg  <= '0;
      ntick_reg  <= 1'b0;
    end else begin
      pin_d_reg  <= pin_d_next;
      idle_reg   <= idle_next;
      det_reg    <= det_next;
      ext_reg    <= ext_next;
      osc_en_reg <= osc_en_next;
      osc_reg    <= osc_next;
      notch_reg  <= notch_next;
      ntick_reg  <= ntick_next;
    end
  end

  // Outputs straight from flip-flops
  assign serial_out     = so_reg;
  assign serial_out_oe  = oe_reg;
  assign conv_start     = start_reg;
  assign conv_busy      = busy_reg;
  assign active_cfg     = used_reg;
  assign ext_clock_mode = ext_reg;
  assign int_osc_enable = osc_en_reg;
  assign notch_tick     = ntick_reg;

endmodule : acso_top

// ==== dv/acso_top_asserts.sv ====
`timescale 1ns/100ps
// Port-level checks on the serial link, the result path and the clock source
module acso_top_asserts
  import acso_pkg::*;
(
  input wire logic         clk,             // System clock
  input wire logic         reset,           // Sync reset
  input wire logic         cs_n,            // Chip select
  input wire logic         sck,             // Serial clock
  input wire logic         serial_out,      // Serial data
  input wire logic         serial_out_oe,   // Drive enable
  input wire logic         cfg_load,        // Config load
  input wire acso_cfg_s    cfg_in,          // Config word
  input wire acso_result_s result_in,       // Modulator result
  input wire logic         conv_start,      // Start pulse
  input wire logic         conv_busy,       // Converting
  input wire acso_cfg_s    active_cfg,      // Applied config
  input wire logic         conv_clock_pin,  // Frequency pin
  input wire logic         ext_clock_mode,  // External clock
  input wire logic         int_osc_enable,  // Internal osc on
  input wire logic         notch_tick       // Notch pulse
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // Pin released one cycle after deselect
  chk_tristate_idle: assert property (cs_n |=> !serial_out_oe)
    else $error("serial_out driven while deselected");
  chk_drive_sel: assert property (!cs_n |=> serial_out_oe)
    else $error("serial_out not driven while selected");
  chk_osc_swap: assert property (int_osc_enable == !ext_clock_mode)
    else $error("oscillator enable disagrees with clock mode");
  chk_start_pulse: assert property (conv_start |-> conv_busy ##1 !conv_start)
    else $error("start pulse malformed");
  chk_done_drop: assert property (result_in.valid && conv_busy |=> !conv_busy)
    else $error("busy stayed high after result");
  // Source may only swap outside a conversion
  chk_src_frozen: assert property ($past(conv_busy) |-> $stable(ext_clock_mode))
    else $error("clock source changed mid conversion");
  // Extra clocks and running conversion read as one
  chk_extra_ones: assert property ($past(conv_busy) && !$past(result_in.valid)
    && serial_out_oe |-> serial_out)
    else $error("serial_out low during conversion");
  chk_eoc_fall: assert property ($past(conv_busy) && $past(result_in.valid) && !cs_n
    && !$past(cs_n) |-> ##[0:1] (serial_out_oe && !serial_out))
    else $error("done flag did not fall");
  chk_temp_unity: assert property (active_cfg.temp_input_select |->
    active_cfg.gain_select == 3'h0 && !active_cfg.double_speed_select)
    else $error("temperature input not forced to unity");
  chk_cfg_latch: assert property ($changed(active_cfg)
    |-> conv_start || $past(conv_start))
    else $error("config changed outside a start");
  chk_notch_once: assert property (notch_tick |=> !notch_tick)
    else $error("notch tick longer than one cycle");
  cover property (conv_start && !$past(conv_busy));
  cover property ($rose(ext_clock_mode));
  cover property ($fell(serial_out) && serial_out_oe);
endmodule : acso_top_asserts

bind acso_top acso_top_asserts acso_top_asserts_inst (.clk(clk), .reset(reset), .cs_n(cs_n),
  .sck(sck), .serial_out(serial_out), .serial_out_oe(serial_out_oe), .cfg_load(cfg_load),
  .cfg_in(cfg_in), .result_in(result_in), .conv_start(conv_start), .conv_busy(conv_busy),
  .active_cfg(active_cfg), .conv_clock_pin(conv_clock_pin),
  .ext_clock_mode(ext_clock_mode), .int_osc_enable(int_osc_enable),
  .notch_tick(notch_tick));

// ==== dv/acso_host.sv ====
`timescale 1ns/100ps
// Host model: owns chip select and serial clock, samples on each rise
module acso_host (
  input  wire logic clk,            // System clock
  input  wire logic serial_out,     // Data from device
  input  wire logic serial_out_oe,  // Device drive enable
  output logic      cs_n,           // Chip select, active low
  output logic      sck             // Serial clock, still outside frames
);
  initial begin
    cs_n = 1'h1;
    sck  = 1'h0;
  end
  // Chip select change, just after a falling clk edge
  task automatic select(input logic lvl);
    @(negedge clk);
    cs_n = lvl;
  endtask : select
  // Clock n bits, two clk per phase; a late bit is captured at the rise
  task automatic read(input int n, output logic [31:0] bits);
    bits = 32'hFFFFFFFF;
    if (cs_n) select(1'h0);
    repeat (2) @(negedge clk);
    for (int i = 0; i < n; i++) begin
      sck  = 1'h1;
      // Undriven line read as the inverse, so a float never passes as data
      bits = {bits[30:0], serial_out_oe ? serial_out : ~serial_out};
      repeat (2) @(negedge clk);
      sck  = 1'h0;
      repeat (2) @(negedge clk);
    end
  endtask : read
endmodule : acso_host

// ==== dv/tb_acso_top.sv ====
`timescale 1ns/100ps
// Self-checking bench for frame output and clock source selection
module tb_acso_top;
  import acso_pkg::*;
  typedef struct {logic signed [19:0] val; logic temp; logic [23:0] exp;} acso_row_s;
  logic         clk, reset, cs_n, sck, serial_out, serial_out_oe, cfg_load;
  logic         conv_start, conv_busy, conv_clock_pin, ext_clock_mode, int_osc_enable;
  logic         notch_tick;
  acso_cfg_s    cfg_in, active_cfg;
  acso_result_s result_in;
  logic [31:0]  bits;
  logic         first_sign;
  int           err_count = 0, n_checks = 0, cyc = 0, ticks = 0;
  // Rows: value, temp select, expected frame (config is the previous row's)
  acso_row_s rows [8] = '{'{20'sh12345, 1'h0, 24'h300000}, '{20'sh10000, 1'h0, 24'h300000},
    '{20'sh0FFFF, 1'h0, 24'h2FFFF2}, '{20'sh00000, 1'h0, 24'h200004},
    '{20'shFFFFF, 1'h0, 24'h1FFFF6}, '{20'shEFFFF, 1'h0, 24'h0FFFF8},
    '{20'sh80000, 1'h1, 24'h0FFFFA}, '{20'sh08000, 1'h0, 24'h280001}};

  acso_top #(.EXT_TIMEOUT(20), .OSC_DIV(4), .NOTCH_CNT(8)) acso_top_inst (.clk(clk),
    .reset(reset), .cs_n(cs_n), .sck(sck), .serial_out(serial_out),
    .serial_out_oe(serial_out_oe), .cfg_load(cfg_load), .cfg_in(cfg_in),
    .result_in(result_in), .conv_start(conv_start), .conv_busy(conv_busy),
    .active_cfg(active_cfg), .conv_clock_pin(conv_clock_pin),
    .ext_clock_mode(ext_clock_mode), .int_osc_enable(int_osc_enable),
    .notch_tick(notch_tick));
  acso_host acso_host_inst (.clk(clk), .serial_out(serial_out),
    .serial_out_oe(serial_out_oe), .cs_n(cs_n), .sck(sck));

  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  // Hang guard and notch pulse counter
  always @(posedge clk) begin
    cyc++;
    if (notch_tick) ticks++;
    if (cyc == 5000) begin
      err_count++;
      $display("BAD %0t timeout", $time);
      results();
    end
  end
  task automatic check(input logic ok, input string msg);
    n_checks++;
    if (ok !== 1'h1) begin
      err_count++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask : check
  // One-cycle result strobe, config loaded alongside
  task automatic conv(input logic signed [19:0] v);
    @(negedge clk);
    result_in = '{valid: 1'h1, value: v};
    cfg_load  = 1'h1;
    @(negedge clk);
    result_in.valid = 1'h0;
    cfg_load        = 1'h0;
  endtask : conv
  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : results

  initial begin
    reset = 1'h1;
    cfg_load = 1'h0;
    cfg_in = CFG_RESET;
    result_in = '{valid: 1'h0, value: 20'sh00000};
    conv_clock_pin = 1'h0;
    repeat (4) @(negedge clk);
    reset = 1'h0;
    @(negedge clk);
    check(serial_out_oe === 1'h0 && conv_busy === 1'h1, "reset outputs");
    check(active_cfg === CFG_RESET && int_osc_enable === 1'h1, "reset config");
    $display("reset test done");
    // Gain codes 0 to 5 and 7, clamps, range flags, temperature override on code 6
    for (int i = 0; i < 8; i++) begin
      cfg_in = '{gain_select: 3'(i), temp_input_select: rows[i].temp,
                 double_speed_select: rows[i].temp, reject_mode: REJ_50};
      conv(rows[i].val);
      check(conv_busy === 1'h0, "busy after result");
      acso_host_inst.read(32, bits);
      acso_host_inst.select(1'h1);
      check(bits[31:8] === rows[i].exp, "frame content");
      check(bits[7:0] === 8'hFF, "extra clocks read one");
      check(active_cfg === acso_cfg_s'{rows[i].temp ? 3'h0 : 3'(i), rows[i].temp, 1'h0,
            REJ_50}, "applied config");
    end
    $display("frame table done");
    // Abort after five bits, then the next conversion is read in full
    conv(20'sh00010);
    acso_host_inst.read(5, bits);
    acso_host_inst.select(1'h1);
    repeat (2) @(negedge clk);
    check(bits[4:0] === 5'h04 && conv_busy === 1'h1, "abort restarts");
    acso_host_inst.select(1'h0);
    repeat (2) @(negedge clk);
    check(serial_out_oe === 1'h1 && serial_out === 1'h1, "flag while busy");
    conv(20'sh00010);
    @(negedge clk);
    check(serial_out === 1'h0, "flag falls at completion");
    acso_host_inst.read(24, bits);
    acso_host_inst.select(1'h1);
    check(bits[23:0] === 24'h20010E, "frame after abort");
    $display("abort test done");
    // External clock while idle: detect, notch ticks, then fall back
    conv(20'sh00010);
    ticks = 0;
    repeat (20) begin
      repeat (3) @(negedge clk);
      conv_clock_pin = ~conv_clock_pin;
    end
    check(ext_clock_mode === 1'h1 && int_osc_enable === 1'h0, "external detected");
    check(ticks > 0, "notch ticks");
    repeat (40) @(negedge clk);
    check(ext_clock_mode === 1'h0 && int_osc_enable === 1'h1, "internal fallback");
    $display("clock source test done");
    // Double speed zero code: sign alternates between reads; strobe in sleep only loads config
    cfg_in = '{gain_select: 3'h2, temp_input_select: 1'h0, double_speed_select: 1'h1,
               reject_mode: REJ_60};
    conv(20'sh00000);
    acso_host_inst.read(24, bits);
    acso_host_inst.select(1'h1);
    check(bits[23:0] === 24'h20010E, "pending frame kept");
    check(active_cfg === acso_cfg_s'{3'h2, 1'h0, 1'h1, REJ_60}, "speed config");
    for (int k = 0; k < 2; k++) begin
      if (k == 1) first_sign = bits[21];
      conv(20'sh00000);
      acso_host_inst.read(24, bits);
      acso_host_inst.select(1'h1);
      check((bits[23:0] & 24'hDFFFFF) === 24'h000004, "zero code frame");
    end
    check(bits[21] === ~first_sign, "zero code sign toggles");
    $display("double speed test done");
    results();
  end
endmodule : tb_acso_top
